// >>> mcs_sequencer.v
// Sequencer and result latching of a six-channel sampling comparator.
// Assumes the analog comparator result arrives synchronous to i_clk, and the
// oscillator and external sequence clocks arrive as synchronous levels.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_map.vh"

// Functional notes
// RQ1: Channels visited in ascending order from zero, never beyond five.
// RQ2: Three-bit count field selects one to six channels; 110b and 111b invalid.
// RQ3: Each slot has a three-bit source select, codes 0..5, alt pair bit.
// RQ4: Each channel keeps rising and falling 6-bit thresholds, switched with channel.
// RQ5: Threshold code maps to 32 mV per step, 32 to 2016 mV.
// RQ6: Each channel has its own gain divider code, applied while active.
// RQ7: Each sequencing clock edge advances channel, loads threshold, latches result.
// RQ8: External sequencing clock at most 10 kHz, 50 percent duty.
// RQ9: Oscillator clock optionally divided by 2, 4 or 8; the code divides by 4 (code 1) or 8 (code 3), and code 2 stops the clock.
// RQ10: Enable high level or rising edge starts the oscillator.
// RQ11: Asynchronous mode updates each output right after its channel.
// RQ12: Synchronous mode updates all outputs after the last channel.
// RQ13: One sequence-done pulse each time all channels are sampled.
// RQ14: Range level mode latches results every n pulses while enable high.
// RQ15: Enable falling in level mode finishes current sequence, then powers down.
// RQ16: In range mode the done output becomes the seventh-range output.
// RQ17: Range edge mode runs one sequence per enable rising edge.
// RQ18: Sampling level mode latches one channel per clock while enable high.
// RQ19: Sampling edge mode runs one pass per enable rising edge.
// RQ20: Detect mode bit: zero level, one edge.
// RQ21: Range bit: zero sampling, one range.
// RQ22: Mux output bit routes mux to general pin two.
// RQ23: Clock source bit: zero oscillator, one external matrix clock.
// RQ24: Done polarity bit inverts the done signal when one.
// RQ25: Each channel result has its own polarity bit.
// RQ26: New sequence restarts at channel zero; outputs hold last values.
// RQ27: Invalid count code is treated as six channels.
module mcs_sequencer (
	input  wire        i_clk,
	input  wire        i_sys_rst,
	input  wire [7:0]  i_avs_address,
	input  wire        i_avs_read,
	input  wire        i_avs_write,
	input  wire [31:0] i_avs_writedata,
	input  wire [3:0]  i_avs_byteenable,
	output reg  [31:0] o_avs_readdata,
	output reg         o_avs_waitrequest,
	output reg  [1:0]  o_avs_response,
	input  wire        i_enable,
	input  wire        i_osc_clk,
	input  wire        i_ext_clk,
	input  wire        i_cmp_result,
	output reg         o_osc_run,
	output reg  [2:0]  o_mux_select,
	output reg         o_mux_alt,
	output reg         o_mux_pin_out_enable,
	output reg  [5:0]  o_ref_code,
	output reg  [1:0]  o_gain_select,
	output reg  [5:0]  o_results,
	output reg         o_sequence_done
);

	// =====================================================================
	// States
	localparam [1:0] ST_IDLE = 2'b01;
	localparam [1:0] ST_RUN  = 2'b10;

	// =====================================================================
	// Registers
	reg [31:0] mode_ff;
	reg [17:0] slot_ff;
	reg [18:0] chan_ff [0:`MCS_NCH-1];
	reg [1:0]  state_ff;
	reg [2:0]  chan_ff_idx;
	reg [5:0]  pend_ff;
	reg        raw_done_ff;
	reg [2:0]  div_ff;
	reg        src_d_ff;
	reg        en_d_ff;
	reg        tick_armed_ff;
	reg        rng_seen_ff;
	reg        last_cmp_ff;
	reg        acc_ff;

	wire       det_edge  = mode_ff[`MCS_F_DET];
	wire       sync_mode = mode_ff[`MCS_F_SYNC];
	wire       rng_mode  = mode_ff[`MCS_F_RNG];
	wire       done_pol  = mode_ff[`MCS_F_DONEPOL];
	wire [1:0] div_sel   = mode_ff[`MCS_F_DIV_LO +: 2];
	wire [2:0] cnt_code  = mode_ff[`MCS_F_CNT_LO +: 3];
	wire [5:0] alt_bits  = mode_ff[`MCS_F_ALT_LO +: 6];

	// Invalid counts run all six channels
	function [2:0] last_chan;
		input [2:0] code;
		begin
			last_chan = (code > `MCS_MAX_CODE) ? `MCS_MAX_CODE : code; // RQ2 RQ27
		end
	endfunction

	// Six three-bit slot sources packed low to high in the slot register
	function [2:0] slot_src;
		input [2:0]  idx;
		input [17:0] slots;
		begin
			case (idx)
				3'h0: slot_src = slots[2:0];
				3'h1: slot_src = slots[5:3];
				3'h2: slot_src = slots[8:6];
				3'h3: slot_src = slots[11:9];
				3'h4: slot_src = slots[14:12];
				default: slot_src = slots[17:15];
			endcase
		end
	endfunction

	// =====================================================================
	// Sequencing clock: divided oscillator or external clock
	wire       src_level = mode_ff[`MCS_F_CLKSRC] ? i_ext_clk : div_ff[div_sel == 2'h0 ? 0 :
	                       (div_sel == 2'h1 ? 1 : (div_sel == 2'h2 ? 2 : 2))]; // RQ23
	wire       osc_level = (div_sel == 2'h0) ? i_osc_clk : src_level;
	wire       seq_level = mode_ff[`MCS_F_CLKSRC] ? i_ext_clk : osc_level;
	wire       seq_tick  = seq_level & ~src_d_ff & tick_armed_ff; // RQ7
	wire       en_rise   = i_enable & ~en_d_ff;
	wire       start     = det_edge ? en_rise : i_enable; // RQ20 RQ10
	wire [2:0] last      = last_chan(cnt_code);
	wire       at_last   = (chan_ff_idx == last);

	reg        osc_d_ff;
	wire [2:0] nxt_div = div_ff + 3'h1;

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			div_ff   <= 3'h0;
			osc_d_ff <= 1'b0;
		end else begin
			osc_d_ff <= i_osc_clk;
			if (i_osc_clk & ~osc_d_ff) begin
				div_ff <= (div_sel == 2'h3) ? nxt_div : {1'b0, nxt_div[1:0]}; // RQ9
			end
		end
	end

	// =====================================================================
	// Sequencer
	wire       cmp_bit   = i_cmp_result ^ chan_ff[chan_ff_idx][`MCS_F_CHPOL]; // RQ25
	wire [5:0] cur_mask  = 6'h01 << chan_ff_idx;

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			state_ff      <= ST_IDLE;
			chan_ff_idx   <= 3'h0;
			pend_ff       <= 6'h00;
			raw_done_ff   <= 1'b0;
			src_d_ff      <= 1'b0;
			en_d_ff       <= 1'b0;
			tick_armed_ff <= 1'b0;
			rng_seen_ff   <= 1'b0;
			last_cmp_ff   <= 1'b0;
			acc_ff        <= 1'b0;
			o_results     <= 6'h00;
			o_osc_run     <= 1'b0;
		end else begin
			src_d_ff    <= seq_level;
			en_d_ff     <= i_enable;
			raw_done_ff <= 1'b0;
			case (state_ff)
				ST_IDLE: begin
					chan_ff_idx   <= 3'h0; // RQ26
					tick_armed_ff <= 1'b0;
					o_osc_run     <= 1'b0;
					if (start) begin // RQ17 RQ19
						state_ff      <= ST_RUN;
						o_osc_run     <= 1'b1;
						tick_armed_ff <= 1'b1;
						pend_ff       <= o_results;
						acc_ff        <= 1'b1;
					end
				end
				ST_RUN: begin
					o_osc_run <= 1'b1;
					if (seq_tick) begin
						// Each channel latches in its own slot; sync mode holds them
						pend_ff <= (pend_ff & ~cur_mask) | ({6{cmp_bit}} & cur_mask);
						// Range mode always latches the whole set at the sequence end
						if (!(sync_mode || rng_mode)) begin
							o_results <= (o_results & ~cur_mask) | ({6{cmp_bit}} & cur_mask); // RQ11 RQ18
						end
						acc_ff <= acc_ff & cmp_bit;
						if (at_last) begin // RQ1
							chan_ff_idx <= 3'h0;
							raw_done_ff <= 1'b1; // RQ13
							rng_seen_ff <= acc_ff & cmp_bit;
							acc_ff      <= 1'b1;
							if (sync_mode || rng_mode) begin
								o_results <= (pend_ff & ~cur_mask) | ({6{cmp_bit}} & cur_mask); // RQ12 RQ14 RQ17
							end
							// Level mode stops only at a sequence boundary
							if (det_edge || !i_enable) begin // RQ15
								state_ff <= ST_IDLE;
							end
						end else begin
							chan_ff_idx <= chan_ff_idx + 3'h1; // RQ7
						end
					end
				end
				default: state_ff <= ST_IDLE;
			endcase
		end
	end

	// =====================================================================
	// Analog steering outputs
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			o_mux_select         <= 3'h0;
			o_mux_alt            <= 1'b0;
			o_mux_pin_out_enable <= 1'b0;
			o_ref_code           <= 6'h00;
			o_gain_select        <= 2'h0;
			o_sequence_done      <= 1'b0;
			last_cmp_ff          <= 1'b0;
		end else begin
			o_mux_select         <= slot_src(chan_ff_idx, slot_ff); // RQ3
			o_mux_alt            <= alt_bits[chan_ff_idx];
			o_mux_pin_out_enable <= mode_ff[`MCS_F_MUXOUT]; // RQ22
			// Rising-edge threshold while output low, falling one while high
			last_cmp_ff          <= o_results[chan_ff_idx];
			o_ref_code           <= last_cmp_ff ? chan_ff[chan_ff_idx][`MCS_F_H2L_LO +: 6]
			                                    : chan_ff[chan_ff_idx][`MCS_F_L2H_LO +: 6]; // RQ4 RQ5
			o_gain_select        <= chan_ff[chan_ff_idx][`MCS_F_GAIN_LO +: 2]; // RQ6
			o_sequence_done      <= (rng_mode ? rng_seen_ff : raw_done_ff) ^ done_pol; // RQ16 RQ24 RQ21
		end
	end

	// =====================================================================
	// Avalon-MM slave: one wait cycle, answer on the second edge
	reg         busy_ff;
	wire        req      = i_avs_read | i_avs_write;
	wire [7:0]  ch_off   = i_avs_address - `MCS_REG_CH_BASE;
	wire        is_ch    = (i_avs_address >= `MCS_REG_CH_BASE) &&
	                       (i_avs_address < `MCS_REG_STATUS) && (i_avs_address[1:0] == 2'h0);
	wire [2:0]  ch_sel   = ch_off[4:2];
	wire [31:0] be_mask  = {{8{i_avs_byteenable[3]}}, {8{i_avs_byteenable[2]}},
	                        {8{i_avs_byteenable[1]}}, {8{i_avs_byteenable[0]}}};
	wire        do_op    = req & busy_ff;

	genvar gi;
	generate
		for (gi = 0; gi < `MCS_NCH; gi = gi + 1) begin : g_chan
			always @(posedge i_clk or posedge i_sys_rst) begin
				if (i_sys_rst) begin
					chan_ff[gi] <= `MCS_CH_RST;
				end else if (do_op && i_avs_write && is_ch && ch_sel == gi) begin
					chan_ff[gi] <= (chan_ff[gi] & ~be_mask[18:0]) |
					               (i_avs_writedata[18:0] & be_mask[18:0]);
				end
			end
		end
	endgenerate

	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst) begin
			mode_ff           <= `MCS_MODE_RST;
			slot_ff           <= `MCS_SLOT_RST;
			busy_ff           <= 1'b0;
			o_avs_waitrequest <= 1'b1;
			o_avs_readdata    <= 32'h0000_0000;
			o_avs_response    <= 2'h0;
		end else begin
			busy_ff           <= req & ~busy_ff;
			o_avs_waitrequest <= ~(req & ~busy_ff);
			if (req & ~busy_ff) begin
				o_avs_response <= 2'h0;
				o_avs_readdata <= 32'h0000_0000;
				if (i_avs_address == `MCS_REG_MODE) begin
					o_avs_readdata <= {14'h0000, mode_ff[17:0]};
				end else if (i_avs_address == `MCS_REG_SLOT_SEL) begin
					o_avs_readdata <= {14'h0000, slot_ff};
				end else if (is_ch) begin
					o_avs_readdata <= {13'h0000, chan_ff[ch_sel]};
				end else if (i_avs_address == `MCS_REG_STATUS) begin
					o_avs_readdata <= {26'h0000000, o_osc_run, chan_ff_idx, state_ff};
				end else if (i_avs_address == `MCS_REG_RESULT) begin
					o_avs_readdata <= {26'h0000000, o_results};
				end else begin
					o_avs_response <= 2'h2;
				end
			end
			if (do_op && i_avs_write) begin
				if (i_avs_address == `MCS_REG_MODE) begin
					mode_ff <= (mode_ff & ~be_mask) | (i_avs_writedata & be_mask & 32'h0003_FFFF);
				end else if (i_avs_address == `MCS_REG_SLOT_SEL) begin
					slot_ff <= (slot_ff & ~be_mask[17:0]) | (i_avs_writedata[17:0] & be_mask[17:0]);
				end
			end
		end
	end

endmodule
`default_nettype wire

// >>> mcs_map.vh
// Register map, field positions, reset values and timing figures of the
// multichannel compare sequencer. Assumes 32-bit Avalon-MM byte addressing, one word per four addresses.
`ifndef MCS_MAP_VH
`define MCS_MAP_VH

// ==========================================================================
// Register byte offsets
`define MCS_REG_MODE       8'h00
`define MCS_REG_SLOT_SEL   8'h04
`define MCS_REG_CH_BASE    8'h10
`define MCS_REG_STATUS     8'h28
`define MCS_REG_RESULT     8'h2C

// ==========================================================================
// Mode register fields
`define MCS_F_DET          0
`define MCS_F_SYNC         1
`define MCS_F_RNG          2
`define MCS_F_MUXOUT       3
`define MCS_F_CLKSRC       4
`define MCS_F_DONEPOL      5
`define MCS_F_DIV_LO       6
`define MCS_F_CNT_LO       8
`define MCS_F_ALT_LO       12

// Per-channel register fields
`define MCS_F_L2H_LO       0
`define MCS_F_H2L_LO       8
`define MCS_F_GAIN_LO      16
`define MCS_F_CHPOL        18

// ==========================================================================
// Reset values
`define MCS_MODE_RST       32'h0000_0000
`define MCS_SLOT_RST       18'h0_8A88
`define MCS_CH_RST         19'h0_0000

// ==========================================================================
// Counts and timing
`define MCS_NCH            6
`define MCS_MAX_CODE       3'h5
`define MCS_REF_STEP_MV    32
`define MCS_EXT_CLK_MAX_HZ 10000
`define MCS_CLK_HZ         250000000
`define MCS_EXT_MIN_PERIOD ((`MCS_CLK_HZ + `MCS_EXT_CLK_MAX_HZ - 1) / `MCS_EXT_CLK_MAX_HZ)

`endif

// >>> mcs_analog_model.sv
// Analog side of the compare sequencer: oscillator, external clock, comparator.
// Assumes the sequencer samples these levels on i_clk.
`timescale 1ns/10ps
`default_nettype none
module mcs_analog_model (
	input  wire       i_clk,
	input  wire       i_osc_run,
	input  wire [2:0] i_mux_select,
	input  wire       i_mux_alt,
	input  wire [1:0] i_gain_select,
	input  wire [5:0] i_ref_code,
	output logic      o_osc_clk,
	output logic      o_ext_clk,
	output logic      o_cmp_result
);
	logic [2:0] osc_cnt;
	logic [2:0] ext_cnt;
	initial begin
		o_osc_clk = 1'b0;
		o_ext_clk = 1'b0;
		o_cmp_result = 1'b0;
		osc_cnt = 3'h0;
		ext_cnt = 3'h0;
	end
	// ==========================================================================
	// Clocks and comparator
	always @(posedge i_clk) begin
		// Oscillator stands still unless powered up
		osc_cnt <= i_osc_run ? osc_cnt + 3'h1 : 3'h0;
		if (i_osc_run && osc_cnt[1:0] == 2'h3)
			o_osc_clk <= !o_osc_clk;
		ext_cnt <= (ext_cnt == 3'h5) ? 3'h0 : ext_cnt + 3'h1;
		// Even duty cycle; period scaled down so the run stays short
		if (ext_cnt == 3'h5)
			o_ext_clk <= !o_ext_clk;
		o_cmp_result <= ({i_mux_select, i_mux_alt, 2'b10} >> i_gain_select) > i_ref_code;
	end
endmodule
`default_nettype wire

// >>> mcs_sequencer_assertions.sv
// Port checker for the compare sequencer.
// Assumes mode register writes are full words.
`timescale 1ns/10ps
`default_nettype none
module mcs_checker (
	input wire        i_clk,
	input wire        i_sys_rst,
	input wire [7:0]  i_avs_address,
	input wire        i_avs_read,
	input wire        i_avs_write,
	input wire [31:0] i_avs_writedata,
	input wire [31:0] o_avs_readdata,
	input wire        o_avs_waitrequest,
	input wire [1:0]  o_avs_response,
	input wire        i_enable,
	input wire        o_osc_run,
	input wire        o_mux_pin_out_enable,
	input wire [5:0]  o_results,
	input wire        o_sequence_done
);
	reg [17:0] mode_ff;
	always @(posedge i_clk or posedge i_sys_rst) begin
		if (i_sys_rst)
			mode_ff <= 18'h0_0000;
		else if (i_avs_write && !o_avs_waitrequest && i_avs_address == 8'h00)
			mode_ff <= i_avs_writedata[17:0];
	end
	default clocking @(posedge i_clk); endclocking
	default disable iff (i_sys_rst);
	// ==========================================================================
	// Properties
	bus_answer_a: assert property ((i_avs_read || i_avs_write) && o_avs_waitrequest
		|=> !o_avs_waitrequest) else $error("bus request left waiting");
	wait_pulse_a: assert property (!o_avs_waitrequest |=> o_avs_waitrequest)
		else $error("waitrequest low too long");
	unmapped_err_a: assert property (!o_avs_waitrequest && i_avs_address == 8'hFC
		|-> o_avs_response == 2'b10 && (i_avs_write || o_avs_readdata == 32'h0))
		else $error("unmapped access not refused");
	mode_read_a: assert property (!o_avs_waitrequest && i_avs_read && i_avs_address == 8'h00
		|-> o_avs_readdata == {14'h0000, mode_ff} && o_avs_response == 2'b00)
		else $error("mode readback wrong");
	mux_pin_a: assert property ($changed(mode_ff[3])
		|-> ##[0:1] o_mux_pin_out_enable == mode_ff[3]) else $error("mux pin enable wrong");
	done_pulse_a: assert property (!mode_ff[2] && !mode_ff[5] && o_sequence_done
		|=> !o_sequence_done) else $error("done not a single pulse");
	result_hold_a: assert property (!o_osc_run [*3] |-> $stable(o_results))
		else $error("results changed while idle");
	level_start_a: assert property (!mode_ff[0] && i_enable |-> ##[0:4] o_osc_run)
		else $error("level enable did not start");
	edge_start_a: assert property (mode_ff[0] && $rose(i_enable) |-> ##[0:4] o_osc_run)
		else $error("enable edge did not start");
	cover property ($rose(o_sequence_done));
	cover property (!o_avs_waitrequest && i_avs_address == 8'hFC);
	cover property (mode_ff[2] && $fell(o_osc_run));
endmodule
bind mcs_sequencer mcs_checker u_chk (.*);
`default_nettype wire

// >>> tb_top.sv
// Self-checking bench for the compare sequencer.
// Assumes the analog model drives the clock and comparator inputs.
`timescale 1ns/10ps
`default_nettype none
`include "mcs_map.vh"
module tb_top;
	logic        i_clk = 1'b0;
	logic        i_sys_rst = 1'b1;
	logic [7:0]  i_avs_address = 8'h00;
	logic        i_avs_read = 1'b0;
	logic        i_avs_write = 1'b0;
	logic [31:0] i_avs_writedata = 32'h0;
	logic [3:0]  i_avs_byteenable = 4'hF;
	logic        i_enable = 1'b0;
	wire  [31:0] o_avs_readdata;
	wire  [1:0]  o_avs_response;
	wire  [1:0]  o_gain_select;
	wire  [2:0]  o_mux_select;
	wire  [5:0]  o_ref_code;
	wire  [5:0]  o_results;
	wire         o_avs_waitrequest;
	wire         i_osc_clk;
	wire         i_ext_clk;
	wire         i_cmp_result;
	wire         o_osc_run;
	wire         o_mux_alt;
	wire         o_mux_pin_out_enable;
	wire         o_sequence_done;
	localparam logic [5:0] THR = 6'h06;
	// Edge ext /8 n3; edge sync /4 bad count; level n5; range edge inverted done
	logic [31:0] modes [4] = '{32'h02D1, 32'h074B, 32'h0400, 32'h0525};
	logic [17:0] slots [4] = '{18'h2C688, 18'h2C688, 18'h2C688, 18'h24924};
	logic [31:0] rd;
	logic [1:0]  rs;
	logic [5:0]  exp_res = 6'h00;
	int          mismatches = 0;
	int          checks_done = 0;
	int          c;
	int          k;
	int          n;
	always #2 i_clk = ~i_clk;
	mcs_sequencer u_dut (.*);
	mcs_analog_model u_ana (.i_clk(i_clk), .i_osc_run(o_osc_run), .i_mux_select(o_mux_select),
		.i_mux_alt(o_mux_alt), .i_gain_select(o_gain_select), .i_ref_code(o_ref_code),
		.o_osc_clk(i_osc_clk), .o_ext_clk(i_ext_clk), .o_cmp_result(i_cmp_result));
	// ==========================================================================
	// Tasks
	function automatic logic [31:0] chw(int ch);
		return {13'h0, ch == 2, 2'(ch % 4), 2'b00, THR, 2'b00, THR};
	endfunction
	task bus(input logic w, input logic [7:0] a, input logic [31:0] wd);
		begin
			@(posedge i_clk);
			i_avs_address <= a;
			i_avs_writedata <= wd;
			i_avs_write <= w;
			i_avs_read <= !w;
			do
				@(posedge i_clk);
			while (o_avs_waitrequest !== 1'b0);
			rd = o_avs_readdata;
			rs = o_avs_response;
			i_avs_write <= 1'b0;
			i_avs_read <= 1'b0;
		end
	endtask
	task chk(input string nm, input logic [31:0] e, input logic [31:0] g);
		checks_done++;
		if (e !== g) begin
			mismatches++;
			$display("CHECK FAILED %s expected %h seen %h", nm, e, g);
		end
	endtask
	// Level runs keep enable up long enough for a second pass
	task run(input logic edge_mode);
		int t;
		begin
			@(posedge i_clk) i_enable <= 1'b1;
			repeat (edge_mode ? 2 : 80) @(posedge i_clk);
			i_enable <= 1'b0;
			t = 0;
			while (o_osc_run !== 1'b1 && t < 20) begin
				@(posedge i_clk);
				t++;
			end
			while (o_osc_run !== 1'b0 && t < 3000) begin
				@(posedge i_clk);
				t++;
			end
			if (t >= 3000)
				chk("run finished", 32'h0, 32'h1);
			repeat (4) @(posedge i_clk);
		end
	endtask
	task print_verdict;
		$display("checks %0d mismatches %0d", checks_done, mismatches);
		if (mismatches == 0 && checks_done > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask
	// ==========================================================================
	// Sequence
	initial begin
		#200000;
		mismatches++;
		print_verdict;
	end
	initial begin
		repeat (6) @(posedge i_clk);
		i_sys_rst <= 1'b0;
		bus(0, `MCS_REG_MODE, 0);
		chk("mode reset", `MCS_MODE_RST, rd);
		bus(0, `MCS_REG_SLOT_SEL, 0);
		chk("slot reset", {14'h0, `MCS_SLOT_RST}, rd);
		bus(1, 8'hFC, 32'hFFFF_FFFF);
		bus(0, 8'hFC, 0);
		chk("unmapped response", 2'b10, rs);
		chk("unmapped data", 0, rd);
		for (k = 0; k < 6; k++)
			bus(1, `MCS_REG_CH_BASE + 8'(4 * k), chw(k));
		bus(0, `MCS_REG_CH_BASE + 8'h08, 0);
		chk("channel two", chw(2), rd);
		for (c = 0; c < 4; c++) begin
			bus(1, `MCS_REG_SLOT_SEL, {14'h0, slots[c]});
			bus(1, `MCS_REG_MODE, modes[c]);
			bus(0, `MCS_REG_MODE, 0);
			chk("mode readback", modes[c], rd);
			run(modes[c][0]);
			n = (modes[c][10:8] > 5) ? 6 : modes[c][10:8] + 1;
			for (k = 0; k < n; k++)
				exp_res[k] = (({slots[c][3 * k +: 3], 3'b010} >> (k % 4)) > THR) ^ (k == 2);
			chk("results", exp_res, o_results);
			bus(0, `MCS_REG_RESULT, 0);
			chk("result register", {26'h0, exp_res}, rd);
			if (modes[c][2])
				chk("seventh range", &exp_res ^ modes[c][5], o_sequence_done);
			chk("mux pin", modes[c][3], o_mux_pin_out_enable);
		end
		print_verdict;
	end
endmodule
`default_nettype wire
